// *** hw/cgu_pkg.sv ***
// constants for the upper configuration bytes and the test-mode select
// assumes byte-wide register indices from the serial management engine
package cgu_pkg;

    // ==========================================================
    // register indices
    localparam logic [7:0] CGU_IDX_PART_ID      = 8'h0C;
    localparam logic [7:0] CGU_IDX_RSVD_A       = 8'h0D;
    localparam logic [7:0] CGU_IDX_RSVD_B       = 8'h0E;
    localparam logic [7:0] CGU_IDX_READBACK_LEN = 8'h0F;
    localparam logic [7:0] CGU_IDX_RSVD_FIRST   = 8'h10;
    localparam logic [7:0] CGU_IDX_RSVD_LAST    = 8'h28;
    localparam logic [7:0] CGU_IDX_PROG_ENABLE  = 8'h29;

    // ==========================================================
    // field layout
    localparam int         CGU_PART_ID_LSB      = 4;
    localparam int         CGU_READBACK_MSB     = 5;
    localparam int         CGU_CPU_ENABLE_BIT   = 1;
    localparam int         CGU_LCD_ENABLE_BIT   = 0;

    // ==========================================================
    // values after reset
    localparam logic [5:0] CGU_READBACK_RESET   = 6'h0F;
    localparam logic [1:0] CGU_PROG_EN_RESET    = 2'h0;
    localparam logic [7:0] CGU_READ_ZERO        = 8'h00;

    // ==========================================================
    // output behaviour chosen by the test pins
    typedef enum logic [1:0] {
        CGU_OUT_NORMAL,
        CGU_OUT_HIZ,
        CGU_OUT_REF_DIV
    } cgu_out_mode_type;

endpackage

// *** hw/cgu_upper_regs.sv ***
// upper configuration bytes and pin-selected test mode of the clock chip
// assumes the serial engine presents a byte index, a one-cycle write
// strobe and reads back one cycle later; test pins are synchronous
//
// Function
// - index 12 reads fixed part identifier in bits 7:4, reserved low nibble
// - indices 13 and 14 are reserved bytes reading zero
// - index 15 holds six-bit readback count, resets to fifteen
// - indices 16 through 40 are reserved, no control function
// - index 41 bit 1 gates CPU divider programming, resets zero
// - index 41 bit 0 gates LCD divider programming, resets zero
// - test mode only if test-select pin high at power-up
// - test mode holds until power is cycled
// - in test mode, mode pin low gives hi-z, high gives ref/N
`timescale 1ns/100ps

module cgu_upper_regs
    import cgu_pkg::*;
#(
    parameter logic [3:0] PART_ID = 4'h5   // arbitrary value
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  regIndex,
    input  wire logic        regWrite,
    input  wire logic [7:0]  regWriteData,
    output logic      [7:0]  regReadData,
    output logic      [5:0]  readbackLength,
    input  wire logic        cpuDividerWriteReq,
    output logic             cpuDividerWriteAccept,
    input  wire logic        lcdDividerWriteReq,
    output logic             lcdDividerWriteAccept,
    input  wire logic        testSel,
    input  wire logic        testModePin,
    output logic             testModeActive,
    output logic             outputsHiZ,
    output logic             outputsRefDiv
);

    // ==========================================================
    // register file
    logic [5:0] readbackLen_q;
    logic [5:0] readbackLen_d;
    logic       cpuProgEn_q;
    logic       cpuProgEn_d;
    logic       lcdProgEn_q;
    logic       lcdProgEn_d;
    logic [7:0] readData_q;
    logic [7:0] readData_d;

    function automatic logic [7:0] readMux(
        input logic [7:0] idx,
        input logic [5:0] len,
        input logic       cpuEn,
        input logic       lcdEn
    );
        logic [7:0] val;
        val = CGU_READ_ZERO;
        unique case (idx)
            CGU_IDX_PART_ID:
                val = {PART_ID, 4'h0};
            CGU_IDX_READBACK_LEN:
                val = {2'h0, len};
            CGU_IDX_PROG_ENABLE:
                val = {6'h00, cpuEn, lcdEn};
            default:
                val = CGU_READ_ZERO;
        endcase
        return val;
    endfunction

    // one decoder for every write target keeps strobe and index
    // qualification in a single place
    function automatic logic writeHit(
        input logic       strobe,
        input logic [7:0] idx,
        input logic [7:0] target
    );
        return strobe && (idx == target);
    endfunction

    // ==========================================================
    // readback count
    always_comb begin
        readbackLen_d = readbackLen_q;
        // count write
        // bits 7:6 are reserved and are never stored
        if (writeHit(regWrite, regIndex, CGU_IDX_READBACK_LEN)) begin
            readbackLen_d = regWriteData[CGU_READBACK_MSB:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            readbackLen_q <= CGU_READBACK_RESET;
        end else begin
            readbackLen_q <= readbackLen_d;
        end
    end

    assign readbackLength = readbackLen_q;

    // ==========================================================
    // divider programming enables
    always_comb begin
        cpuProgEn_d = cpuProgEn_q;
        lcdProgEn_d = lcdProgEn_q;
        // bits 7:2 are reserved and are never stored
        if (writeHit(regWrite, regIndex, CGU_IDX_PROG_ENABLE)) begin
            cpuProgEn_d = regWriteData[CGU_CPU_ENABLE_BIT];
            lcdProgEn_d = regWriteData[CGU_LCD_ENABLE_BIT];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cpuProgEn_q <= CGU_PROG_EN_RESET[CGU_CPU_ENABLE_BIT];
            lcdProgEn_q <= CGU_PROG_EN_RESET[CGU_LCD_ENABLE_BIT];
        end else begin
            cpuProgEn_q <= cpuProgEn_d;
            lcdProgEn_q <= lcdProgEn_d;
        end
    end

    // ==========================================================
    // read data
    // writes to read-only and reserved bytes are dropped silently; a
    // read sees the registers as they stood before a same-edge write
    always_comb begin
        readData_d = readMux(regIndex, readbackLen_q, cpuProgEn_q,
                             lcdProgEn_q);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            readData_q <= CGU_READ_ZERO;
        end else begin
            readData_q <= readData_d;
        end
    end

    assign regReadData = readData_q;

    // ==========================================================
    // divider programming gates
    logic [1:0] gateReq;
    logic [1:0] gateEn;
    logic [1:0] gateAccept;

    assign gateReq[CGU_CPU_ENABLE_BIT] = cpuDividerWriteReq;
    assign gateReq[CGU_LCD_ENABLE_BIT] = lcdDividerWriteReq;
    assign gateEn[CGU_CPU_ENABLE_BIT]  = cpuProgEn_q;
    assign gateEn[CGU_LCD_ENABLE_BIT]  = lcdProgEn_q;

    // enable is a flop, so a request never sees a same-edge write
    for (genvar g = 0; g < 2; g++) begin : gGate
        assign gateAccept[g] = gateReq[g] & gateEn[g];
    end

    assign cpuDividerWriteAccept = gateAccept[CGU_CPU_ENABLE_BIT];
    assign lcdDividerWriteAccept = gateAccept[CGU_LCD_ENABLE_BIT];

    // ==========================================================
    // test-mode selection
    logic             strapTaken_q;
    logic             strapTaken_d;
    logic             testLatched_q;
    logic             testLatched_d;
    cgu_out_mode_type mode_q;
    cgu_out_mode_type mode_d;

    // strap at power-up
    // pin is caught once on the first edge after release; an async
    // reset may only load a constant, so it cannot sample the pin
    always_comb begin
        strapTaken_d  = 1'b1;
        testLatched_d = testLatched_q;
        if (!strapTaken_q) begin
            testLatched_d = testSel;
        end
    end

    // sticky until power
    // no later edge can clear it; only rst (power-on) does
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            strapTaken_q  <= 1'b0;
            testLatched_q <= 1'b0;
        end else begin
            strapTaken_q  <= strapTaken_d;
            testLatched_q <= testLatched_d;
        end
    end

    assign testModeActive = testLatched_q;

    // ==========================================================
    // output mode
    // decoded from the next strap value so the flags are already right
    // on the very edge that takes the strap
    always_comb begin
        mode_d = CGU_OUT_NORMAL;
        if (testLatched_d) begin
            mode_d = testModePin ? CGU_OUT_REF_DIV : CGU_OUT_HIZ;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_q <= CGU_OUT_NORMAL;
        end else begin
            mode_q <= mode_d;
        end
    end

    assign outputsHiZ    = (mode_q == CGU_OUT_HIZ);
    assign outputsRefDiv = (mode_q == CGU_OUT_REF_DIV);

endmodule

// *** sim/cgu_host_model.sv ***
// serial management host model driving the byte register port
// assumes the design samples on rising clk; drives at falling edges
`timescale 1ns/100ps
module cgu_host_model (
    input  wire logic       clk,
    output logic      [7:0] regIndex,
    output logic            regWrite,
    output logic      [7:0] regWriteData
);
    initial begin
        regIndex = 8'h00;
        regWrite = 1'b0;
        regWriteData = 8'h00;
    end
    // ==========
    // one byte access, held across exactly one rising edge
    task automatic xfer(input logic [7:0] i, input logic w,
                        input logic [7:0] d);
        @(negedge clk);
        regIndex = i;
        regWrite = w;
        regWriteData = d;
        @(negedge clk);
        regWrite = 1'b0;
        // released data never repeats the last byte
        regWriteData = ~d;
    endtask
endmodule

// *** sim/cgu_upper_regs_monitor.sv ***
// assertions on the upper configuration byte ports
// assumes a bind onto cgu_upper_regs, single clock domain
`timescale 1ns/100ps
module cgu_upper_regs_monitor
    import cgu_pkg::*;
#(parameter logic [3:0] PART_ID = 4'h5) (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic [7:0] regIndex,
    input wire logic       regWrite,
    input wire logic [7:0] regWriteData,
    input wire logic [7:0] regReadData,
    input wire logic [5:0] readbackLength,
    input wire logic       cpuDividerWriteReq,
    input wire logic       cpuDividerWriteAccept,
    input wire logic       lcdDividerWriteReq,
    input wire logic       lcdDividerWriteAccept,
    input wire logic       testSel,
    input wire logic       testModePin,
    input wire logic       testModeActive,
    input wire logic       outputsHiZ,
    input wire logic       outputsRefDiv
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_part_id_read: assert property (regIndex == 8'h0C |=>
        regReadData == {PART_ID, 4'h0}) else $error("id byte");
    a_reserved_zero: assert property (regIndex inside
        {8'h0D, 8'h0E, [8'h10:8'h28]} |=> regReadData == 8'h00)
        else $error("reserved byte");
    a_length_write: assert property (regWrite && regIndex == 8'h0F |=>
        {2'h0, readbackLength} == ($past(regWriteData) & 8'h3F))
        else $error("length store");
    a_cpu_gate: assert property (regWrite && regIndex == 8'h29 ##1
        cpuDividerWriteReq |-> cpuDividerWriteAccept ==
        |($past(regWriteData) & 8'h02)) else $error("cpu gate");
    a_lcd_gate: assert property (regWrite && regIndex == 8'h29 ##1
        lcdDividerWriteReq |-> lcdDividerWriteAccept ==
        |($past(regWriteData) & 8'h01)) else $error("lcd gate");
    a_test_sticky: assert property (testModeActive |=>
        testModeActive) else $error("test mode lost");
    a_select_latch: assert property (!testModeActive && !$past(rst)
        |=> !testModeActive && !outputsHiZ && !outputsRefDiv)
        else $error("late test entry");
    a_test_outputs: assert property (testModeActive |->
        outputsRefDiv == $past(testModePin) &&
        outputsHiZ == !$past(testModePin)) else $error("test outputs");
    c_prog_write: cover property (regWrite && regIndex == 8'h29);
    c_hiz: cover property (outputsHiZ);
    c_ref_div: cover property (outputsRefDiv);
endmodule

// *** sim/cgu_upper_regs_test.sv ***
// self-checking bench for the upper config bytes and test pins
// assumes the host model owns the register port
`timescale 1ns/100ps
module cgu_upper_regs_test;
    import cgu_pkg::*;
    localparam logic [3:0] PART_ID = 4'hA;  // arbitrary value
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cpuDividerWriteReq = 1'b0;
    logic lcdDividerWriteReq = 1'b0;
    logic testSel = 1'b0;
    logic testModePin = 1'b0;
    logic regWrite, cpuDividerWriteAccept, lcdDividerWriteAccept;
    logic testModeActive, outputsHiZ, outputsRefDiv;
    logic [7:0] regIndex, regWriteData, regReadData;
    logic [5:0] readbackLength;
    int fail_count = 0;
    int compares = 0;
    int lenM = 15;
    int enM = 0;
    always #4 clk = ~clk;
    cgu_host_model cgu_host_model_i (
        .clk(clk), .regIndex(regIndex), .regWrite(regWrite),
        .regWriteData(regWriteData)
    );
    cgu_upper_regs #(.PART_ID(PART_ID)) cgu_upper_regs_i (
        .clk(clk), .rst(rst), .regIndex(regIndex), .regWrite(regWrite),
        .regWriteData(regWriteData), .regReadData(regReadData),
        .readbackLength(readbackLength),
        .cpuDividerWriteReq(cpuDividerWriteReq),
        .cpuDividerWriteAccept(cpuDividerWriteAccept),
        .lcdDividerWriteReq(lcdDividerWriteReq),
        .lcdDividerWriteAccept(lcdDividerWriteAccept),
        .testSel(testSel), .testModePin(testModePin),
        .testModeActive(testModeActive), .outputsHiZ(outputsHiZ),
        .outputsRefDiv(outputsRefDiv)
    );
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        if (fail_count == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    function automatic logic [7:0] model(input logic [7:0] i);
        if (i == 8'h0C) return {PART_ID, 4'h0};
        if (i == 8'h0F) return 8'(lenM);
        if (i == 8'h29) return 8'(enM);
        return 8'h00;
    endfunction
    // write when asked, then read back and probe the divider gates
    task automatic poke(input logic [7:0] i, input logic w,
                        input logic [7:0] d);
        if (w) cgu_host_model_i.xfer(i, 1'b1, d);
        if (w && i == 8'h0F) lenM = d & 8'h3F;
        if (w && i == 8'h29) enM = d & 8'h03;
        cgu_host_model_i.xfer(i, 1'b0, 8'h00);
        chk(regReadData, model(i));
        chk({2'h0, readbackLength}, 8'(lenM));
        cpuDividerWriteReq = 1'($urandom);
        lcdDividerWriteReq = 1'($urandom);
        testModePin = 1'($urandom);
        // a late strap must never enter test mode
        testSel = 1'($urandom);
        #1;
        chk({6'h0, cpuDividerWriteAccept, lcdDividerWriteAccept},
            8'(enM & {cpuDividerWriteReq, lcdDividerWriteReq}));
        chk({5'h0, testModeActive, outputsHiZ, outputsRefDiv}, 8'h00);
    endtask
    initial begin
        void'($urandom(72225));
        repeat (16) @(negedge clk);
        rst = 1'b0;
        for (int k = 0; k < 30; k++) poke(8'(12 + k), 1'b0, 8'h00);
        for (int k = 0; k < 60; k++)
            poke(8'(k % 3 == 0 ? 15 : k % 3 == 1 ? 41 : $urandom % 64),
                 1'b1, 8'($urandom));
        // power cycle with the select strap high
        rst = 1'b1;
        lenM = 15;
        enM = 0;
        testSel = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        for (int k = 0; k < 20; k++) begin
            testModePin = 1'($urandom);
            if (k > 0) testSel = 1'($urandom);
            @(negedge clk);
            chk({5'h0, testModeActive, outputsHiZ, outputsRefDiv},
                {5'h0, 1'b1, !testModePin, testModePin});
            chk({2'h0, readbackLength}, 8'(lenM));
        end
        test_done;
    end
    initial begin
        #40000;
        fail_count++;
        test_done;
    end
endmodule
bind cgu_upper_regs cgu_upper_regs_monitor #(.PART_ID(PART_ID)) mon_i (
    .clk(clk), .rst(rst), .regIndex(regIndex), .regWrite(regWrite),
    .regWriteData(regWriteData), .regReadData(regReadData),
    .readbackLength(readbackLength),
    .cpuDividerWriteReq(cpuDividerWriteReq),
    .cpuDividerWriteAccept(cpuDividerWriteAccept),
    .lcdDividerWriteReq(lcdDividerWriteReq),
    .lcdDividerWriteAccept(lcdDividerWriteAccept),
    .testSel(testSel), .testModePin(testModePin),
    .testModeActive(testModeActive), .outputsHiZ(outputsHiZ),
    .outputsRefDiv(outputsRefDiv)
);
